// ---- logic/mii_pkg.sv ----
// Shared constants for the nibble interface between the PHY end and the MAC end
`default_nettype none
package mii_pkg;
    // Core clock
    localparam int CORE_CLK_HZ = 50_000_000;
    localparam int CORE_CLK_MHZ = 50;
    // Nibble clock rates for the two speeds
    localparam int RATE_SLOW_HZ = 2_500_000;
    localparam int RATE_FAST_HZ = 25_000_000;
    // Half periods of the nibble clocks in core cycles
    localparam int HALF_SLOW_CYC = CORE_CLK_HZ / (2 * RATE_SLOW_HZ);
    localparam int HALF_FAST_CYC = (CORE_CLK_HZ / (2 * RATE_FAST_HZ)) < 1 ? 1 : CORE_CLK_HZ / (2 * RATE_FAST_HZ);
    // Interface strap codes
    localparam logic [2:0] STRAP_MII = 3'h0;
    localparam logic [2:0] STRAP_B2B = 3'h6;
    // Cycles after reset release before the strap is latched
    localparam logic [1:0] STRAP_WAIT = 2'h2;
    // Frame nibbles
    localparam logic [3:0] PREAMBLE_NIB = 4'h5;
    localparam logic [3:0] SFD_LO_NIB = 4'h5;
    localparam logic [3:0] SFD_HI_NIB = 4'hD;
    localparam logic [3:0] IDLE_NIB = 4'h0;
    // Jabber limits, in ms, and their core cycle counts
    localparam int JABBER_MS = 20;
    localparam int UNJABBER_MS = 250;
    localparam int JABBER_CYC = JABBER_MS * (CORE_CLK_HZ / 1000);
    localparam int UNJABBER_CYC = UNJABBER_MS * (CORE_CLK_HZ / 1000);
    // Heartbeat pulse length after each slow-speed transmitted frame
    localparam int SQE_NS = 1000;
    localparam int SQE_CYC = (SQE_NS * CORE_CLK_MHZ + 999) / 1000;
endpackage
`default_nettype wire

// ---- logic/mii_if.sv ----
// Nibble interface joining the PHY end and the MAC end
`timescale 1ns/1ns
`default_nettype none
interface mii_if;
    logic txc;
    logic tx_en;
    logic [3:0] txd;
    logic rxc;
    logic rx_dv;
    logic [3:0] rxd;
    logic rx_er;
    logic crs;
    logic col;

    // PHY drives both clocks and all receive indications
    modport phy (output txc, rxc, rx_dv, rxd, rx_er, crs, col, input tx_en, txd);
    // MAC drives the transmit group
    modport mac (input txc, rxc, rx_dv, rxd, rx_er, crs, col, output tx_en, txd);
endinterface
`default_nettype wire

// ---- logic/mii_mac_end.sv ----
// MAC end of the nibble interface: sends and collects nibbles on the PHY clocks
`timescale 1ns/1ns
`default_nettype none
module mii_mac_end import mii_pkg::*; (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Link to the PHY
    mii_if.mac mii,
    // Transmit request
    input wire logic tx_valid,
    input wire logic [3:0] tx_nib,
    output logic tx_ready,
    // Receive delivery
    output logic [3:0] rx_nib,
    output logic rx_stb,
    output logic frame_valid,
    output logic frame_err,
    // Line indications
    output logic carrier,
    output logic collision
);
    localparam int SW = 10;

    logic [SW-1:0] pin_raw;
    logic [SW-1:0] pin_s1_r;
    logic [SW-1:0] pin_s2_r;
    logic txc_s3_r;
    logic rxc_s3_r;
    logic txc_rise;
    logic rxc_rise;
    logic tx_en_r;
    logic [3:0] txd_r;
    logic [3:0] rx_nib_r;
    logic rx_stb_r;
    logic dv_r;
    logic er_r;

    // Pins from the PHY, bundled for the synchroniser
    assign pin_raw = {mii.txc, mii.rxc, mii.rx_dv, mii.rxd, mii.rx_er, mii.crs, mii.col};

    // Two flip-flops on every pin from the PHY
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            txc_s3_r <= 1'b0;
            rxc_s3_r <= 1'b0;
        end else begin
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            txc_s3_r <= pin_s2_r[9];
            rxc_s3_r <= pin_s2_r[8];
        end
    end

    // Rising edges of the two nibble clocks
    assign txc_rise = pin_s2_r[9] & ~txc_s3_r;
    assign rxc_rise = pin_s2_r[8] & ~rxc_s3_r;
    assign tx_ready = txc_rise;

    // Transmit group changes only on a seen TXC rise, idle nibble is zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_en_r <= 1'b0;
            txd_r <= IDLE_NIB;
        end else if (txc_rise) begin
            tx_en_r <= tx_valid;
            txd_r <= tx_valid ? tx_nib : IDLE_NIB;
        end
    end

    assign mii.tx_en = tx_en_r;
    assign mii.txd = txd_r;

    // Receive group sampled on a seen RXC rise
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_nib_r <= IDLE_NIB;
            rx_stb_r <= 1'b0;
            dv_r <= 1'b0;
            er_r <= 1'b0;
        end else if (rxc_rise) begin
            rx_nib_r <= pin_s2_r[6:3];
            rx_stb_r <= pin_s2_r[7];
            dv_r <= pin_s2_r[7];
            er_r <= pin_s2_r[2];
        end else begin
            rx_stb_r <= 1'b0;
        end
    end

    assign rx_nib = rx_nib_r;
    assign rx_stb = rx_stb_r;
    assign frame_valid = dv_r;
    assign frame_err = er_r;
    assign carrier = pin_s2_r[1];
    assign collision = pin_s2_r[0];
endmodule
`default_nettype wire

// ---- logic/mii_phy_end.sv ----
// PHY end of the nibble interface: clocks, receive framing, carrier and collision
//
// Summary of operation
// - TXC runs always, 2.5 or 25 MHz.
// - MAC frames TXEN around every frame nibble.
// - MAC changes transmit lines only with TXC.
// - Nibbles taken while TXEN high; idle zero.
// - Slow speed: recovered clock only during carrier.
// - Fast speed: recovered clock unless link down.
// - RXC 2.5 or 25 MHz, times receive group.
// - Slow speed: RXDV rises on SFD.
// - Fast speed: RXDV spans preamble to end.
// - One nibble per RXC while RXDV high.
// - Symbol errors raise RXER, RXC synchronous.
// - Slow speed: CRS preamble to frame end.
// - Fast speed: CRS J/K to T/R or idle.
// - Half duplex: COL on simultaneous activity.
// - Strap 000 selects normal MAC operation.
// - Strap 110 selects back-to-back repeater mode.
// - Back-to-back: receive group feeds peer transmit.
// - Both speeds, both duplexes, separate nibble groups.
// - Slow speed: heartbeat pulse on COL after frames.
// - Slow speed: jabber cut-off after 20 ms, release 250 ms.
`timescale 1ns/1ns
`default_nettype none
module mii_phy_end import mii_pkg::*; #(
    parameter int JAB_CYC = JABBER_CYC,
    parameter int UNJAB_CYC = UNJABBER_CYC,
    parameter int SQE_LEN = SQE_CYC,
    parameter int HALF_SLOW = HALF_SLOW_CYC,
    parameter int HALF_FAST = HALF_FAST_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Link to the MAC or peer
    mii_if.phy mii,
    // Strap pins and resolved link state
    input wire logic [2:0] config_strap,
    input wire logic link_up,
    input wire logic speed_100,
    input wire logic full_duplex,
    // Recovered clock half-period tick
    input wire logic rec_tick,
    // Line receive side
    input wire logic line_rx_act,
    input wire logic [3:0] line_rx_nib,
    input wire logic line_rx_sym_err,
    input wire logic line_jk,
    input wire logic line_tr,
    input wire logic line_idle,
    output logic line_rx_take,
    // Line transmit side
    output logic line_tx_en,
    output logic [3:0] line_tx_nib,
    output logic line_tx_stb,
    // Mode status
    output logic mode_b2b,
    output logic strap_done
);
    localparam logic [7:0] HALF_SLOW_W = 8'(HALF_SLOW - 1);
    localparam logic [7:0] HALF_FAST_W = 8'(HALF_FAST - 1);
    localparam logic [23:0] JAB_W = 24'(JAB_CYC - 1);
    localparam logic [23:0] UNJAB_W = 24'(UNJAB_CYC - 1);
    localparam logic [7:0] SQE_W = 8'(SQE_LEN);

    logic [2:0] strap_s1_r, strap_s2_r;
    logic [1:0] strap_cnt_r;
    logic strap_done_r, b2b_r;
    logic fast;
    logic [7:0] txdiv_r, rxdiv_r;
    logic txc_r, rxc_r;
    logic tx_tick, tx_fall, rx_tick, rx_fall, recovering;
    logic tx_en_s1_r, tx_en_s2_r, tx_en_d_r;
    logic [3:0] txd_s1_r, txd_s2_r;
    logic ltx_en_r, ltx_stb_r;
    logic [3:0] ltx_nib_r;
    logic [3:0] prev_nib_r;
    logic prev_act_r, prev_err_r;
    logic dv_r, er_r, dv_nxt, er_nxt;
    logic [3:0] rxd_r, rxd_nxt;
    logic crs_r, col_r;
    logic jab_r;
    logic [23:0] jab_cnt_r;
    logic [7:0] sqe_cnt_r;

    // End of a half period for the selected speed
    function automatic logic div_end(input logic [7:0] cnt, input logic sel_fast);
        return cnt == (sel_fast ? HALF_FAST_W : HALF_SLOW_W);
    endfunction

    // Strap pins synchronised, then latched once after reset release
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            strap_s1_r <= 3'h0;
            strap_s2_r <= 3'h0;
        end else begin
            strap_s1_r <= config_strap;
            strap_s2_r <= strap_s1_r;
        end
    end

    // Interface mode choice; codes other than the two known ones act as normal
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            strap_cnt_r <= 2'h0;
            strap_done_r <= 1'b0;
            b2b_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            if (strap_cnt_r == STRAP_WAIT) begin
                strap_done_r <= 1'b1;
                b2b_r <= (strap_s2_r == STRAP_B2B);
            end
        end
    end

    // Repeater mode always runs at the fast rate
    assign fast = b2b_r | speed_100;

    // Transmit clock divider, free running
    assign tx_tick = div_end(txdiv_r, fast);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            txdiv_r <= 8'h00;
            txc_r <= 1'b0;
        end else if (tx_tick) begin
            txdiv_r <= 8'h00;
            txc_r <= ~txc_r;
        end else begin
            txdiv_r <= txdiv_r + 8'h01;
        end
    end
    assign tx_fall = tx_tick & txc_r;

    // Receive clock: recovered ticks or the local divider
    assign recovering = link_up & (fast | line_rx_act);
    assign rx_tick = recovering ? rec_tick : div_end(rxdiv_r, fast);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rxdiv_r <= 8'h00;
            rxc_r <= 1'b0;
        end else begin
            rxdiv_r <= div_end(rxdiv_r, fast) ? 8'h00 : rxdiv_r + 8'h01;
            if (rx_tick) begin
                rxc_r <= ~rxc_r;
            end
        end
    end
    assign rx_fall = rx_tick & rxc_r;
    assign line_rx_take = rx_fall;

    // Transmit pins synchronised
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_en_s1_r <= 1'b0;
            tx_en_s2_r <= 1'b0;
            tx_en_d_r <= 1'b0;
            txd_s1_r <= IDLE_NIB;
            txd_s2_r <= IDLE_NIB;
        end else begin
            tx_en_s1_r <= mii.tx_en;
            tx_en_s2_r <= tx_en_s1_r;
            tx_en_d_r <= tx_en_s2_r;
            txd_s1_r <= mii.txd;
            txd_s2_r <= txd_s1_r;
        end
    end

    // Transmit nibble taken mid-period, away from the MAC's change point
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ltx_en_r <= 1'b0;
            ltx_nib_r <= IDLE_NIB;
            ltx_stb_r <= 1'b0;
        end else if (tx_fall) begin
            ltx_en_r <= tx_en_s2_r & ~jab_r;
            ltx_nib_r <= tx_en_s2_r ? txd_s2_r : IDLE_NIB;
            ltx_stb_r <= tx_en_s2_r & ~jab_r;
        end else begin
            ltx_stb_r <= 1'b0;
        end
    end
    assign line_tx_en = ltx_en_r;
    assign line_tx_nib = ltx_nib_r;
    assign line_tx_stb = ltx_stb_r;

    // One nibble of lookahead, used to find the SFD at the slow speed
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_nib_r <= IDLE_NIB;
            prev_act_r <= 1'b0;
            prev_err_r <= 1'b0;
        end else if (rx_fall) begin
            prev_nib_r <= line_rx_nib;
            prev_act_r <= line_rx_act;
            prev_err_r <= line_rx_sym_err & line_rx_act;
        end
    end

    // Next receive group
    always_comb begin
        if (fast) begin
            dv_nxt = line_rx_act;
            rxd_nxt = line_rx_nib;
            er_nxt = line_rx_sym_err & line_rx_act;
        end else begin
            dv_nxt = prev_act_r & (dv_r | (prev_nib_r == SFD_LO_NIB && line_rx_nib == SFD_HI_NIB && line_rx_act));
            rxd_nxt = prev_nib_r;
            er_nxt = prev_err_r & dv_nxt;
        end
        if (!dv_nxt) begin
            rxd_nxt = IDLE_NIB;
        end
    end

    // Receive group changes on the RXC falling edge, steady at the rising one
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dv_r <= 1'b0;
            rxd_r <= IDLE_NIB;
            er_r <= 1'b0;
        end else if (rx_fall) begin
            dv_r <= dv_nxt;
            rxd_r <= rxd_nxt;
            er_r <= er_nxt;
        end
    end

    // Carrier sense; a set in the same cycle as a clear wins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            crs_r <= 1'b0;
        end else if (fast) begin
            if (line_tr || line_idle || !link_up) begin
                crs_r <= 1'b0;
            end
            if (line_jk) begin
                crs_r <= 1'b1;
            end
        end else begin
            if (!line_rx_act) begin
                crs_r <= 1'b0;
            end
            if (line_rx_act && line_rx_nib == PREAMBLE_NIB) begin
                crs_r <= 1'b1;
            end
        end
    end

    // Jabber: long slow-speed transmit cuts the line, long silence restores it
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            jab_r <= 1'b0;
            jab_cnt_r <= 24'h000000;
        end else if (!jab_r) begin
            if (tx_en_s2_r && !fast) begin
                jab_cnt_r <= jab_cnt_r + 24'h000001;
                if (jab_cnt_r == JAB_W) begin
                    jab_r <= 1'b1;
                    jab_cnt_r <= 24'h000000;
                end
            end else begin
                jab_cnt_r <= 24'h000000;
            end
        end else if (!tx_en_s2_r) begin
            jab_cnt_r <= jab_cnt_r + 24'h000001;
            if (jab_cnt_r == UNJAB_W) begin
                jab_r <= 1'b0;
                jab_cnt_r <= 24'h000000;
            end
        end else begin
            jab_cnt_r <= 24'h000000;
        end
    end

    // Heartbeat timer started at the end of each slow-speed frame, unless jabber has cut the line
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sqe_cnt_r <= 8'h00;
        end else if (tx_en_d_r && !tx_en_s2_r && !fast && !jab_r) begin
            sqe_cnt_r <= SQE_W;
        end else if (sqe_cnt_r != 8'h00) begin
            sqe_cnt_r <= sqe_cnt_r - 8'h01;
        end
    end

    // Collision, not tied to either nibble clock
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            col_r <= 1'b0;
        end else begin
            col_r <= (~full_duplex & tx_en_s2_r & line_rx_act) | (sqe_cnt_r != 8'h00) | jab_r;
        end
    end

    // Pins toward the MAC or the peer's transmit group
    assign mii.txc = txc_r;
    assign mii.rxc = rxc_r;
    assign mii.rx_dv = dv_r;
    assign mii.rxd = rxd_r;
    assign mii.rx_er = er_r;
    assign mii.crs = crs_r;
    assign mii.col = col_r;
    assign mode_b2b = b2b_r;
    assign strap_done = strap_done_r;
endmodule
`default_nettype wire

// ---- verif/mii_link_sva.sv ----
// Concurrent checks on the signals of the nibble interface
`timescale 1ns/1ns
`default_nettype none
module mii_link_sva #(
    parameter int HALF_SLOW = 10,
    parameter int HALF_FAST = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Interface signals
    input wire logic txc,
    input wire logic tx_en,
    input wire logic [3:0] txd,
    input wire logic rxc,
    input wire logic rx_dv,
    input wire logic [3:0] rxd,
    input wire logic rx_er,
    input wire logic crs,
    input wire logic col
);
    int txc_cnt_r;
    int rxc_cnt_r;
    logic txc_seen_r;
    logic txc_d_r;
    logic rxc_d_r;
    // Cycles since the last transmit clock edge
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            txc_d_r <= 1'b0;
            txc_cnt_r <= 0;
            txc_seen_r <= 1'b0;
        end else begin
            txc_d_r <= txc;
            txc_cnt_r <= (txc != txc_d_r) ? 0 : txc_cnt_r + 1;
            txc_seen_r <= txc_seen_r | (txc != txc_d_r);
        end
    end
    // Cycles since the last receive clock edge
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rxc_d_r <= 1'b0;
            rxc_cnt_r <= 0;
        end else begin
            rxc_d_r <= rxc;
            rxc_cnt_r <= (rxc != rxc_d_r) ? 0 : rxc_cnt_r + 1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Idle levels, clock alignment and clock rates
    idle_txd_a: assert property (!tx_en |-> txd == 4'h0)
        else $error("txd not zero while tx_en low");
    tx_sync_a: assert property (($changed(tx_en) || $changed(txd)) |-> txc)
        else $error("transmit group changed while txc low");
    rx_sync_a: assert property (($changed(rx_dv) || $changed(rxd)) |-> !rxc)
        else $error("receive group changed while rxc high");
    rxer_sync_a: assert property ($changed(rx_er) |-> !rxc)
        else $error("rx_er changed while rxc high");
    idle_rxd_a: assert property (!rx_dv && !rx_er |-> rxd == 4'h0)
        else $error("rxd not zero while idle");
    txc_half_a: assert property ((txc != txc_d_r) && txc_seen_r |->
        (txc_cnt_r == HALF_SLOW - 1 || txc_cnt_r == HALF_FAST - 1))
        else $error("txc half period wrong");
    rxc_half_a: assert property ((rxc != rxc_d_r) |-> rxc_cnt_r < 2 * HALF_SLOW)
        else $error("rxc stalled");
    crs_frame_a: assert property ($rose(rx_dv) |-> crs)
        else $error("rx_dv rose without carrier");
endmodule
`default_nettype wire

// ---- verif/phy_mii_nibble_interface_tb.sv ----
// Bench joining the PHY end and the MAC end across the nibble interface
`timescale 1ns/1ns
`default_nettype none
module phy_mii_nibble_interface_tb;
    import mii_pkg::*;
    localparam int HS = 10;
    localparam int HF = 6;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] config_strap = 3'h0;
    logic link_up = 1'b1;
    logic speed_100 = 1'b0;
    logic full_duplex = 1'b0;
    logic rec_tick = 1'b0;
    logic line_rx_act = 1'b0;
    logic [3:0] line_rx_nib = 4'h0;
    logic line_rx_sym_err = 1'b0;
    logic line_jk = 1'b0;
    logic line_tr = 1'b0;
    logic line_idle = 1'b0;
    logic tx_valid = 1'b0;
    logic [3:0] tx_nib = 4'h0;
    logic line_rx_take, line_tx_en, line_tx_stb, mode_b2b, strap_done;
    logic tx_ready, rx_stb, frame_valid, frame_err, carrier, collision;
    logic [3:0] line_tx_nib, rx_nib;
    logic [3:0] q[$];
    int mismatches = 0;
    int samples_checked = 0;
    int tick_cnt = 0;
    mii_if mii();
    mii_phy_end #(.JAB_CYC(200), .UNJAB_CYC(80), .SQE_LEN(4), .HALF_SLOW(HS), .HALF_FAST(HF)) u_mii_phy_end (
        .core_clk(core_clk), .rst(rst), .mii(mii), .config_strap(config_strap), .link_up(link_up),
        .speed_100(speed_100), .full_duplex(full_duplex), .rec_tick(rec_tick), .line_rx_act(line_rx_act),
        .line_rx_nib(line_rx_nib), .line_rx_sym_err(line_rx_sym_err), .line_jk(line_jk), .line_tr(line_tr),
        .line_idle(line_idle), .line_rx_take(line_rx_take), .line_tx_en(line_tx_en), .line_tx_nib(line_tx_nib),
        .line_tx_stb(line_tx_stb), .mode_b2b(mode_b2b), .strap_done(strap_done));
    mii_mac_end u_mii_mac_end (
        .core_clk(core_clk), .rst(rst), .mii(mii), .tx_valid(tx_valid), .tx_nib(tx_nib), .tx_ready(tx_ready),
        .rx_nib(rx_nib), .rx_stb(rx_stb), .frame_valid(frame_valid), .frame_err(frame_err),
        .carrier(carrier), .collision(collision));
    mii_link_sva #(.HALF_SLOW(HS), .HALF_FAST(HF)) u_sva (
        .core_clk(core_clk), .rst(rst), .txc(mii.txc), .tx_en(mii.tx_en), .txd(mii.txd), .rxc(mii.rxc),
        .rx_dv(mii.rx_dv), .rxd(mii.rxd), .rx_er(mii.rx_er), .crs(mii.crs), .col(mii.col));
    // Core clock
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    // Recovered clock half-period ticks, 160 ns period
    always @(posedge core_clk) begin
        #1;
        tick_cnt = tick_cnt + 1;
        rec_tick = (tick_cnt % 4 == 0);
    end
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic timeout();
        mismatches++;
        $display("ERROR wait limit expected 1 seen 0");
        wrap_up();
    endtask
    task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // Reset with a strap and speed, then check the latched mode
    task automatic do_reset(input logic [2:0] strap, input logic fast, input logic exp_b2b);
        int n;
        rst = 1'b1;
        config_strap = strap;
        speed_100 = fast;
        step(3);
        rst = 1'b0;
        n = 0;
        while (strap_done !== 1'b1) begin
            step(1);
            n++;
            if (n > 20) timeout();
        end
        chk("strap_latency", 4'h3, 4'(n));
        chk("mode_b2b", {3'h0, exp_b2b}, {3'h0, mode_b2b});
    endtask
    // One transmitted frame, optionally against line receive activity
    task automatic tx_frame(input logic fast, input logic fd, input logic busy, input logic col_exp);
        logic [3:0] fr[6] = '{4'h5, 4'h5, 4'hD, 4'h0, 4'h8, 4'hF};
        logic cs;
        int n;
        do_reset(3'h0, fast, 1'b0);
        full_duplex = fd;
        cs = 1'b0;
        q.delete();
        line_jk = busy;
        step(1);
        line_jk = 1'b0;
        line_rx_act = busy;
        fork
            begin
                foreach (fr[i]) begin
                    tx_valid = 1'b1;
                    tx_nib = fr[i];
                    n = 0;
                    // Ready seen settled in this cycle: the MAC takes the nibble at the next edge
                    while (tx_ready !== 1'b1 && n < 100) begin
                        step(1);
                        n++;
                    end
                    if (n >= 100) timeout();
                    step(1);
                end
                tx_valid = 1'b0;
                tx_nib = 4'h0;
            end
            repeat (400) begin
                step(1);
                if (line_tx_stb === 1'b1) q.push_back(line_tx_nib & {4{line_tx_en}});
                if (collision === 1'b1) cs = 1'b1;
            end
        join
        line_rx_act = 1'b0;
        line_tr = 1'b1;
        step(1);
        line_tr = 1'b0;
        chk("tx_count", 4'h6, 4'(q.size()));
        foreach (fr[i]) chk("tx_nibble", fr[i], q[i]);
        chk("collision", {3'h0, col_exp}, {3'h0, cs});
    endtask
    // One received frame with a symbol error, ended by T/R or by idle
    task automatic rx_frame(input logic fast, input logic end_idle);
        logic [3:0] fr[8] = '{4'h5, 4'h5, 4'h5, 4'h5, 4'h5, 4'hD, 4'hA, 4'h3};
        logic er;
        logic cr;
        logic tk;
        logic fv;
        int k;
        int n;
        int base;
        do_reset(3'h0, fast, 1'b0);
        full_duplex = 1'b1;
        q.delete();
        er = 1'b0;
        cr = 1'b0;
        fv = 1'b0;
        base = fast ? 0 : 4;
        line_jk = 1'b1;
        step(1);
        line_jk = 1'b0;
        fork
            begin
                k = 0;
                n = 0;
                line_rx_act = 1'b1;
                line_rx_nib = fr[0];
                while (k < 8 && n < 500) begin
                    // Take pulse read settled, mid cycle; the nibble goes at the next edge
                    @(negedge core_clk);
                    tk = line_rx_take;
                    step(1);
                    n++;
                    if (tk === 1'b1) k++;
                    line_rx_nib = (k < 8) ? fr[k & 7] : 4'h0;
                    line_rx_sym_err = (k == 6);
                end
                line_rx_act = 1'b0;
                if (n >= 500) timeout();
            end
            repeat (600) begin
                step(1);
                if (rx_stb === 1'b1) q.push_back(rx_nib);
                if (frame_valid === 1'b1) fv = 1'b1;
                if (frame_err === 1'b1) er = 1'b1;
                if (carrier === 1'b1) cr = 1'b1;
            end
        join
        line_tr = !end_idle;
        line_idle = end_idle;
        step(1);
        line_tr = 1'b0;
        line_idle = 1'b0;
        step(10);
        chk("rx_count", 4'(8 - base), 4'(q.size()));
        foreach (q[i]) chk("rx_nibble", fr[i + base], q[i]);
        chk("frame_err", 4'h1, {3'h0, er});
        chk("carrier_on", 4'h1, {3'h0, cr});
        chk("carrier_off", 4'h0, {3'h0, carrier});
        chk("valid_on", 4'h1, {3'h0, fv});
        chk("valid_off", 4'h0, {3'h0, frame_valid});
    endtask
    // Repeater mode runs the transmit clock at the fast rate
    task automatic b2b_rate();
        int n;
        int h;
        logic lv;
        h = 0;
        repeat (2) begin
            lv = mii.txc;
            n = 0;
            while (mii.txc === lv && n < 100) begin
                step(1);
                n++;
            end
            if (n >= 100) timeout();
            h = n;
        end
        chk("b2b_half", 4'(HF), 4'(h));
    endtask
    // Transmit held on past the jabber limit, then released
    task automatic jabber();
        do_reset(3'h0, 1'b0, 1'b0);
        full_duplex = 1'b1;
        tx_valid = 1'b1;
        tx_nib = 4'h5;
        step(300);
        chk("jab_tx_en", 4'h0, {3'h0, line_tx_en});
        chk("jab_col", 4'h1, {3'h0, collision});
        tx_valid = 1'b0;
        tx_nib = 4'h0;
        step(40);
        chk("jab_hold", 4'h1, {3'h0, collision});
        step(100);
        chk("jab_free", 4'h0, {3'h0, collision});
    endtask
    // Main sequence
    initial begin
        do_reset(3'h6, 1'b0, 1'b1);
        b2b_rate();
        do_reset(3'h3, 1'b0, 1'b0);
        tx_frame(1'b0, 1'b0, 1'b0, 1'b1);
        tx_frame(1'b1, 1'b0, 1'b0, 1'b0);
        tx_frame(1'b1, 1'b0, 1'b1, 1'b1);
        tx_frame(1'b1, 1'b1, 1'b1, 1'b0);
        rx_frame(1'b1, 1'b0);
        rx_frame(1'b1, 1'b1);
        rx_frame(1'b0, 1'b0);
        jabber();
        wrap_up();
    end
endmodule
`default_nettype wire
